// file: dv/cffr_fault_response_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cffr_fault_response_bench;
    import cffr_pkg::*;
    localparam int TICK = 10;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, btn_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [MON_W-1:0] mon;
    logic charge_enable, charge_reduced, timer_running, doubled, rail_en, rail_in, bat_conn, irq;
    int err_count = 0;
    int n_tests = 0;

    always #2 pclk = ~pclk;

    cffr_host cffr_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    cffr_fault_response #(.TICK_CYCLES(TICK)) cffr_fault_response_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .thermal_foldback_active(mon[MB_FOLDBACK]), .input_good_status(mon[MB_INPUT_GOOD]),
        .battery_overcurrent(mon[MB_OVERCURRENT]), .cool_region(mon[MB_COOL]),
        .hot_region(mon[MB_HOT]), .cold_region(mon[MB_COLD]), .thermistor_open(mon[MB_OPEN]),
        .bus_watchdog_expired(mon[MB_WATCHDOG]), .thermal_shutdown(mon[MB_SHUTDOWN]),
        .current_loop_active(mon[MB_CURRENT_LOOP]), .push_button_input_n(btn_n),
        .charge_enable(charge_enable), .charge_reduced(charge_reduced),
        .safety_timer_running(timer_running), .safety_timer_doubled(doubled),
        .system_rail_enable(rail_en), .system_rail_input_powered(rail_in),
        .battery_connected(bat_conn), .irq(irq));

    task automatic wrap_up;
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task automatic chk_pin(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_pin

    task automatic chk_reg(input string name, input logic [7:0] a, input logic [31:0] exp,
                           input logic exp_err);
        logic [31:0] r;
        logic e;
        cffr_host_inst.xfer(1'b0, a, 32'h0000_0000, r, e);
        chk_pin(name, exp, r);
        chk_pin({name, " slverr"}, {31'h0, exp_err}, {31'h0, e});
    endtask : chk_reg

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        cffr_host_inst.xfer(1'b1, a, d, r, e);
    endtask : wr

    task automatic drv(input int b, input logic v);
        @(posedge pclk);
        mon[b] <= v;
    endtask : drv

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : idle

    task automatic t_reset;
        chk_reg("mask", OFS_MASK, 32'h0000_0000, 1'b0);
        chk_reg("ctrl", OFS_CTRL, 32'h0000_0001, 1'b0);
        chk_reg("wake1", OFS_WAKE1, 32'h0000_0064, 1'b0);
        chk_reg("safety", OFS_SAFETY, 32'h0000_FFFF, 1'b0);
        chk_reg("unmapped", 8'h20, 32'h0000_0000, 1'b1);
        chk_pin("irq", 1'b0, irq);
        wr(OFS_FLAGS, 32'h0000_0FFF);
        wr(OFS_MASK, 32'h0000_0FFF);
        chk_reg("flags", OFS_FLAGS, 32'h0000_0000, 1'b0);
    endtask : t_reset

    task automatic t_foldback;
        drv(MB_FOLDBACK, 1'b1);
        idle(8);
        chk_reg("flags", OFS_FLAGS, 32'h0000_0001, 1'b0);
        chk_pin("irq", 1'b1, irq);
        chk_pin("charge", 1'b1, charge_enable);
        chk_pin("reduced", 1'b1, charge_reduced);
        wr(OFS_FLAGS, 32'h0000_0001);
        idle(2);
        chk_pin("irq", 1'b0, irq);
        drv(MB_FOLDBACK, 1'b0);
        idle(8);
    endtask : t_foldback

    task automatic t_input;
        drv(MB_INPUT_GOOD, 1'b0);
        idle(8);
        chk_reg("flags", OFS_FLAGS, 32'h0000_0002, 1'b0);
        chk_pin("charge", 1'b0, charge_enable);
        chk_pin("rail in", 1'b0, rail_in);
        wr(OFS_FLAGS, 32'h0000_0002);
        drv(MB_INPUT_GOOD, 1'b1);
        idle(8);
        chk_reg("flags", OFS_FLAGS, 32'h0000_0002, 1'b0);
        chk_pin("rail in", 1'b1, rail_in);
        wr(OFS_CTRL, 32'h0000_0005);
        idle(3);
        chk_pin("rail in", 1'b0, rail_in);
        wr(OFS_CTRL, 32'h0000_0001);
        wr(OFS_FLAGS, 32'h0000_0FFF);
    endtask : t_input

    task automatic t_events;
        int bits[6] = '{MB_OVERCURRENT, MB_COOL, MB_HOT, MB_COLD, MB_OPEN, MB_WATCHDOG};
        logic chg[6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        foreach (bits[i]) begin
            drv(bits[i], 1'b1);
            idle(8);
            chk_reg("flags", OFS_FLAGS, 32'h1 << bits[i], 1'b0);
            chk_pin("irq", 1'b1, irq);
            chk_pin("charge", chg[i], charge_enable);
            chk_pin("battery", bits[i] != MB_OVERCURRENT, bat_conn);
            drv(bits[i], 1'b0);
            idle(8);
            wr(OFS_FLAGS, 32'h0000_0FFF);
        end
    endtask : t_events

    task automatic t_shutdown;
        drv(MB_SHUTDOWN, 1'b1);
        idle(8);
        chk_reg("flags", OFS_FLAGS, 32'h0000_0000, 1'b0);
        chk_pin("irq", 1'b0, irq);
        chk_pin("charge", 1'b0, charge_enable);
        chk_pin("rail", 1'b0, rail_en);
        chk_pin("timer", 1'b0, timer_running);
        drv(MB_SHUTDOWN, 1'b0);
        idle(8);
    endtask : t_shutdown

    task automatic t_double;
        drv(MB_COOL, 1'b1);
        idle(8);
        chk_pin("doubled", 1'b0, doubled);
        wr(OFS_CTRL, 32'h0000_0003);
        idle(3);
        chk_pin("doubled", 1'b1, doubled);
        wr(OFS_CTRL, 32'h0000_0001);
        drv(MB_COOL, 1'b0);
        idle(8);
        wr(OFS_FLAGS, 32'h0000_0FFF);
    endtask : t_double

    task automatic t_button;
        wr(OFS_WAKE1, 32'h0000_0002);
        wr(OFS_WAKE2, 32'h0000_0005);
        wr(OFS_RESET_WARN, 32'h0000_0008);
        @(posedge pclk);
        btn_n <= 1'b0;
        idle(35);
        chk_reg("flags", OFS_FLAGS, 32'h0000_0200, 1'b0);
        idle(70);
        chk_reg("flags", OFS_FLAGS, 32'h0000_0E00, 1'b0);
        chk_pin("charge", 1'b1, charge_enable);
        @(posedge pclk);
        btn_n <= 1'b1;
        wr(OFS_FLAGS, 32'h0000_0FFF);
    endtask : t_button

    task automatic t_safety;
        wr(OFS_SAFETY, 32'h0000_0003);
        idle(60);
        chk_reg("flags", OFS_FLAGS, 32'h0000_0100, 1'b0);
        chk_pin("charge", 1'b0, charge_enable);
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0001);
        idle(3);
        chk_reg("flags", OFS_FLAGS, 32'h0000_0000, 1'b0);
        chk_pin("charge", 1'b1, charge_enable);
        chk_pin("timer", 1'b1, timer_running);
        chk_reg("flags", OFS_FLAGS, 32'h0000_0000, 1'b0);
        wr(OFS_SAFETY, 32'h0000_FFFF);
    endtask : t_safety

    initial begin
        presetn = 1'b0;
        mon = 10'h002;
        btn_n = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        idle(8);
        t_reset();
        t_foldback();
        t_input();
        t_events();
        t_shutdown();
        t_double();
        t_button();
        t_safety();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        wrap_up();
    end
endmodule : cffr_fault_response_bench
`default_nettype wire

// file: dv/cffr_fault_response_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cffr_fault_response_chk (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic thermal_foldback_active,
    input  wire logic input_good_status,
    input  wire logic battery_overcurrent,
    input  wire logic cool_region,
    input  wire logic hot_region,
    input  wire logic cold_region,
    input  wire logic thermistor_open,
    input  wire logic bus_watchdog_expired,
    input  wire logic thermal_shutdown,
    input  wire logic current_loop_active,
    input  wire logic push_button_input_n,
    input  wire logic charge_enable,
    input  wire logic charge_reduced,
    input  wire logic safety_timer_running,
    input  wire logic safety_timer_doubled,
    input  wire logic system_rail_enable,
    input  wire logic system_rail_input_powered,
    input  wire logic battery_connected,
    input  wire logic irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire pause_cond = hot_region | cold_region | thermistor_open;
    wire slow_cond  = thermal_foldback_active | current_loop_active | cool_region;

    a_shutdown_kills_all: assert property (
        thermal_shutdown [*8] |-> !charge_enable && !system_rail_enable && !safety_timer_running)
        else $error("shutdown left charge, rail or timer on");
    a_overcurrent_cuts_bat: assert property (
        battery_overcurrent [*8] |-> !charge_enable && !battery_connected)
        else $error("over-current left charge or battery on");
    a_input_low_stops: assert property (
        !input_good_status [*8] |->
            !charge_enable && !safety_timer_running && !system_rail_input_powered)
        else $error("input low left charge, timer or rail input");
    a_region_pauses: assert property (
        pause_cond [*8] |-> !charge_enable && !safety_timer_running)
        else $error("hot, cold or open did not pause");
    a_no_double_idle: assert property (
        !slow_cond [*8] |-> !safety_timer_doubled)
        else $error("timer doubled without cause");
    a_foldback_reduces: assert property (
        thermal_foldback_active [*8] ##0 charge_enable |-> charge_reduced)
        else $error("foldback without reduced current");
    a_watchdog_keeps: assert property (
        $rose(bus_watchdog_expired) && charge_enable && !pause_cond |-> charge_enable [*6])
        else $error("watchdog expiry stopped charging");
    a_button_no_effect: assert property (
        $fell(push_button_input_n) |->
            $stable({charge_enable, system_rail_enable, battery_connected}) [*6])
        else $error("button changed charger or rail");

    c_irq: cover property ($rose(irq));
    c_shutdown: cover property (thermal_shutdown [*8]);
    c_doubled: cover property ($rose(safety_timer_doubled));
endmodule : cffr_fault_response_chk

bind cffr_fault_response cffr_fault_response_chk cffr_fault_response_chk_inst (.*);
`default_nettype wire

// file: dv/cffr_host.sv
`timescale 1ns/1ps
`default_nettype none
module cffr_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // Request held until pready; read data and error taken at that edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        err = pslverr;
        rd  = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
        @(negedge pclk);
    endtask : xfer
endmodule : cffr_host
`default_nettype wire

// file: logic/cffr_fault_response.sv
`timescale 1ns/1ps
`default_nettype none
module cffr_fault_response #(
    parameter int TICK_CYCLES = cffr_pkg::TICK_CYCLES
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  thermal_foldback_active,
    input  wire logic                  input_good_status,
    input  wire logic                  battery_overcurrent,
    input  wire logic                  cool_region,
    input  wire logic                  hot_region,
    input  wire logic                  cold_region,
    input  wire logic                  thermistor_open,
    input  wire logic                  bus_watchdog_expired,
    input  wire logic                  thermal_shutdown,
    input  wire logic                  current_loop_active,
    input  wire logic                  push_button_input_n,
    output logic                       charge_enable,
    output logic                       charge_reduced,
    output logic                       safety_timer_running,
    output logic                       safety_timer_doubled,
    output logic                       system_rail_enable,
    output logic                       system_rail_input_powered,
    output logic                       battery_connected,
    output logic                       irq
);
    import cffr_pkg::*;

    localparam int TICK_W = $clog2(TICK_CYCLES + 1);

    typedef struct packed {
        logic [MON_W-1:0]  mon_prev;
        logic [2:0]        btn_hit;
        logic [FLAG_W-1:0] flags;
        logic [FLAG_W-1:0] mask;
        logic [CTRL_W-1:0] ctrl;
        logic [TIME_W-1:0] wake1;
        logic [TIME_W-1:0] wake2;
        logic [TIME_W-1:0] warn;
        logic [TIME_W-1:0] safe;
        logic [TICK_W-1:0] tick_cnt;
        logic              tick;
        logic [TIME_W-1:0] btn_cnt;
        logic              lockout;
        logic              timer_clear;
        logic [31:0]       prdata;
        logic              charge_en;
        logic              reduced;
        logic              doubled;
        logic              rail_en;
        logic              rail_in;
        logic              bat_conn;
        logic              irq;
    } cffr_state_t;

    cffr_state_t s_q, s_d;

    logic [MON_W-1:0]  mon_raw;
    logic [MON_W-1:0]  mon;
    logic              btn_n;
    logic [FLAG_W-1:0] ev;
    logic [FLAG_W-1:0] w1c;
    logic [2:0]        btn_now;
    logic              wr_en;
    logic              rd_en;
    logic              mapped;
    logic              toggle;
    logic              pause;
    logic              tmr_expired;
    logic              tmr_running;
    logic              chg_ok;

    always_comb begin
        mon_raw                  = '0;
        mon_raw[MB_FOLDBACK]     = thermal_foldback_active;
        mon_raw[MB_INPUT_GOOD]   = input_good_status;
        mon_raw[MB_OVERCURRENT]  = battery_overcurrent;
        mon_raw[MB_COOL]         = cool_region;
        mon_raw[MB_HOT]          = hot_region;
        mon_raw[MB_COLD]         = cold_region;
        mon_raw[MB_OPEN]         = thermistor_open;
        mon_raw[MB_WATCHDOG]     = bus_watchdog_expired;
        mon_raw[MB_SHUTDOWN]     = thermal_shutdown;
        mon_raw[MB_CURRENT_LOOP] = current_loop_active;
    end

    cffr_sync #(
        .W   (MON_W),
        .RST (MON_RST)
    ) u_mon_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (mon_raw),
        .sync_out (mon)
    );

    // Button idles high
    cffr_sync #(
        .W   (1),
        .RST (1'b1)
    ) u_btn_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (push_button_input_n),
        .sync_out (btn_n)
    );

    // Hot, cold and open hold the timer count, which restarts from zero once they clear
    assign pause = mon[MB_HOT] | mon[MB_COLD] | mon[MB_OPEN];

    cffr_safety_timer #(
        .W (TIME_W)
    ) u_safety (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (s_q.tick),
        .run     (s_q.charge_en | pause),
        .pause   (pause),
        .clear   (s_q.timer_clear),
        .doubled (s_q.doubled),
        .limit   (s_q.safe),
        .expired (tmr_expired),
        .running (tmr_running)
    );

    assign wr_en  = psel & penable & pwrite;
    assign rd_en  = psel & ~penable & ~pwrite;
    assign mapped = (paddr == OFS_FLAGS) || (paddr == OFS_MASK) || (paddr == OFS_CTRL)
                 || (paddr == OFS_STATUS) || (paddr == OFS_WAKE1) || (paddr == OFS_WAKE2)
                 || (paddr == OFS_RESET_WARN) || (paddr == OFS_SAFETY);

    always_comb begin
        s_d  = s_q;
        ev   = '0;
        w1c  = '0;

        // Microsecond timebase
        s_d.tick = 1'b0;
        if (s_q.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
            s_d.tick_cnt = '0;
            s_d.tick     = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 1'b1;
        end

        // Button hold counter, cleared on release
        if (btn_n) begin
            s_d.btn_cnt = '0;
        end else if (s_q.tick && s_q.btn_cnt != '1) begin
            s_d.btn_cnt = s_q.btn_cnt + 1'b1;
        end
        btn_now[0] = !btn_n && (s_q.btn_cnt >= s_q.wake1);
        btn_now[1] = !btn_n && (s_q.btn_cnt >= s_q.wake2);
        btn_now[2] = !btn_n && (s_q.btn_cnt >= s_q.warn);
        s_d.btn_hit = btn_now;

        // Status edge events
        s_d.mon_prev = mon;
        ev[FB_FOLDBACK]     = mon[MB_FOLDBACK] & ~s_q.mon_prev[MB_FOLDBACK];
        ev[FB_INPUT_CHANGE] = mon[MB_INPUT_GOOD] ^ s_q.mon_prev[MB_INPUT_GOOD];
        ev[FB_OVERCURRENT]  = mon[MB_OVERCURRENT] & ~s_q.mon_prev[MB_OVERCURRENT];
        ev[FB_COOL]         = mon[MB_COOL] & ~s_q.mon_prev[MB_COOL];
        ev[FB_HOT]          = mon[MB_HOT] & ~s_q.mon_prev[MB_HOT];
        ev[FB_COLD]         = mon[MB_COLD] & ~s_q.mon_prev[MB_COLD];
        ev[FB_OPEN]         = mon[MB_OPEN] & ~s_q.mon_prev[MB_OPEN];
        ev[FB_WATCHDOG]     = mon[MB_WATCHDOG] & ~s_q.mon_prev[MB_WATCHDOG];
        ev[FB_SAFETY]       = tmr_expired;
        ev[FB_WAKE1]        = btn_now[0] & ~s_q.btn_hit[0];
        ev[FB_WAKE2]        = btn_now[1] & ~s_q.btn_hit[1];
        ev[FB_RESET_WARN]   = btn_now[2] & ~s_q.btn_hit[2];

        // Register writes
        if (wr_en) begin
            case (paddr)
                OFS_FLAGS:      w1c        = pwdata[FLAG_W-1:0];
                OFS_MASK:       s_d.mask   = pwdata[FLAG_W-1:0];
                OFS_CTRL:       s_d.ctrl   = pwdata[CTRL_W-1:0];
                OFS_WAKE1:      s_d.wake1  = pwdata[TIME_W-1:0];
                OFS_WAKE2:      s_d.wake2  = pwdata[TIME_W-1:0];
                OFS_RESET_WARN: s_d.warn   = pwdata[TIME_W-1:0];
                OFS_SAFETY:     s_d.safe   = pwdata[TIME_W-1:0];
                default:        w1c        = '0;
            endcase
        end
        // Input supply or charge-enable toggle, seen in the same cycle as the write
        toggle = (mon[MB_INPUT_GOOD] ^ s_q.mon_prev[MB_INPUT_GOOD])
               | (s_d.ctrl[CB_CHARGE_EN] ^ s_q.ctrl[CB_CHARGE_EN]);

        // Toggle also clears the safety flag; a new event wins over any clear
        w1c[FB_SAFETY] = w1c[FB_SAFETY] | toggle;
        s_d.flags = (s_q.flags & ~w1c) | ev;

        // Lockout until toggle; a fresh expiry wins
        if (tmr_expired) begin
            s_d.lockout = 1'b1;
        end else if (toggle) begin
            s_d.lockout = 1'b0;
        end
        // Restart timing once the flag is gone, and while input is low
        s_d.timer_clear = (s_q.flags[FB_SAFETY] & ~s_d.flags[FB_SAFETY])
                        | ~mon[MB_INPUT_GOOD]
                        | mon[MB_SHUTDOWN];

        // Charger response
        chg_ok = s_q.ctrl[CB_CHARGE_EN]
               & mon[MB_INPUT_GOOD]
               & ~mon[MB_OVERCURRENT]
               & ~s_d.lockout
               & ~mon[MB_SHUTDOWN]
               & ~pause;
        s_d.charge_en = chg_ok;
        s_d.reduced   = chg_ok & (mon[MB_FOLDBACK] | mon[MB_CURRENT_LOOP] | mon[MB_COOL]);
        s_d.doubled   = s_q.ctrl[CB_DOUBLE_EN]
                      & (mon[MB_FOLDBACK] | mon[MB_CURRENT_LOOP] | mon[MB_COOL]);

        // System rail response
        s_d.rail_en  = ~mon[MB_SHUTDOWN];
        s_d.rail_in  = mon[MB_INPUT_GOOD] & ~mon[MB_SHUTDOWN]
                     & (s_q.ctrl[CTRL_W-1:CB_RAIL_MODE_LO] == RAIL_MODE_INPUT);
        s_d.bat_conn = ~mon[MB_OVERCURRENT] & ~mon[MB_SHUTDOWN];

        s_d.irq = |(s_q.flags & s_q.mask);

        // Read data, registered in setup so it stands through the access phase
        if (rd_en) begin
            case (paddr)
                OFS_FLAGS:      s_d.prdata = 32'(s_q.flags);
                OFS_MASK:       s_d.prdata = 32'(s_q.mask);
                OFS_CTRL:       s_d.prdata = 32'(s_q.ctrl);
                OFS_STATUS:     s_d.prdata = 32'({~btn_n, s_q.lockout, tmr_running,
                                                   s_q.charge_en, s_q.bat_conn, s_q.rail_in,
                                                   mon});
                OFS_WAKE1:      s_d.prdata = 32'(s_q.wake1);
                OFS_WAKE2:      s_d.prdata = 32'(s_q.wake2);
                OFS_RESET_WARN: s_d.prdata = 32'(s_q.warn);
                OFS_SAFETY:     s_d.prdata = 32'(s_q.safe);
                default:        s_d.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q          <= '0;
            s_q.mask     <= MASK_RST;
            s_q.ctrl     <= CTRL_RST;
            s_q.wake1    <= WAKE1_RST;
            s_q.wake2    <= WAKE2_RST;
            s_q.warn     <= WARN_RST;
            s_q.safe     <= SAFE_RST;
            s_q.rail_en  <= 1'b1;
            s_q.bat_conn <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Zero-wait slave; read data already stands when pready is sampled
    assign pready                    = 1'b1;
    assign pslverr                   = psel & penable & ~mapped;
    assign prdata                    = s_q.prdata;
    assign charge_enable             = s_q.charge_en;
    assign charge_reduced            = s_q.reduced;
    assign safety_timer_running      = tmr_running;
    assign safety_timer_doubled      = s_q.doubled;
    assign system_rail_enable        = s_q.rail_en;
    assign system_rail_input_powered = s_q.rail_in;
    assign battery_connected         = s_q.bat_conn;
    assign irq                       = s_q.irq;

endmodule : cffr_fault_response
`default_nettype wire

// file: logic/cffr_pkg.sv
package cffr_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_FLAGS      = 8'h00;
    localparam logic [7:0] OFS_MASK       = 8'h04;
    localparam logic [7:0] OFS_CTRL       = 8'h08;
    localparam logic [7:0] OFS_STATUS     = 8'h0C;
    localparam logic [7:0] OFS_WAKE1      = 8'h10;
    localparam logic [7:0] OFS_WAKE2      = 8'h14;
    localparam logic [7:0] OFS_RESET_WARN = 8'h18;
    localparam logic [7:0] OFS_SAFETY     = 8'h1C;

    // Flag bit positions, shared by flag and mask registers
    localparam int FLAG_W            = 12;
    localparam int FB_FOLDBACK       = 0;
    localparam int FB_INPUT_CHANGE   = 1;
    localparam int FB_OVERCURRENT    = 2;
    localparam int FB_COOL           = 3;
    localparam int FB_HOT            = 4;
    localparam int FB_COLD           = 5;
    localparam int FB_OPEN           = 6;
    localparam int FB_WATCHDOG       = 7;
    localparam int FB_SAFETY         = 8;
    localparam int FB_WAKE1          = 9;
    localparam int FB_WAKE2          = 10;
    localparam int FB_RESET_WARN     = 11;

    // Control register fields
    localparam int CB_CHARGE_EN      = 0;
    localparam int CB_DOUBLE_EN      = 1;
    localparam int CB_RAIL_MODE_LO   = 2;
    localparam int CTRL_W            = 4;
    localparam logic [1:0] RAIL_MODE_INPUT = 2'h0;

    // Synchronised monitor inputs, also status register bits 9:0
    localparam int MON_W             = 10;
    localparam int MB_FOLDBACK       = 0;
    localparam int MB_INPUT_GOOD     = 1;
    localparam int MB_OVERCURRENT    = 2;
    localparam int MB_COOL           = 3;
    localparam int MB_HOT            = 4;
    localparam int MB_COLD           = 5;
    localparam int MB_OPEN           = 6;
    localparam int MB_WATCHDOG       = 7;
    localparam int MB_SHUTDOWN       = 8;
    localparam int MB_CURRENT_LOOP   = 9;
    localparam int STAT_W            = 16;

    // Reset values
    localparam logic [FLAG_W-1:0] MASK_RST  = 12'h000;
    localparam logic [CTRL_W-1:0] CTRL_RST  = 4'h1;
    localparam logic [MON_W-1:0]  MON_RST   = 10'h000;
    localparam int TIME_W                   = 16;
    localparam logic [TIME_W-1:0] WAKE1_RST = 16'h0064;
    localparam logic [TIME_W-1:0] WAKE2_RST = 16'h07D0;
    localparam logic [TIME_W-1:0] WARN_RST  = 16'h2EE0;
    localparam logic [TIME_W-1:0] SAFE_RST  = 16'hFFFF;

    // Timebase: one tick per microsecond at the bus clock rate
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TICK_US       = 1000;
    localparam int TICK_CYCLES   = (TICK_US * 1000) / CLK_PERIOD_PS;

endpackage : cffr_pkg

// file: logic/cffr_safety_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cffr_safety_timer #(
    parameter int W = 16
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           tick,
    input  wire logic           run,
    input  wire logic           pause,
    input  wire logic           clear,
    input  wire logic           doubled,
    input  wire logic [W-1:0]   limit,
    output logic                expired,
    output logic                running
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         half;
        logic         done;
        logic         expired;
    } cffr_tmr_t;

    cffr_tmr_t t_q, t_d;
    logic      adv;

    always_comb begin
        t_d         = t_q;
        t_d.expired = 1'b0;
        adv         = 1'b0;
        if (clear || !run) begin
            t_d.cnt  = '0;
            t_d.half = 1'b0;
            t_d.done = 1'b0;
        end else if (tick && !pause && !t_q.done) begin
            // Doubled duration: count every second tick
            if (doubled) begin
                t_d.half = ~t_q.half;
                adv      = t_q.half;
            end else begin
                adv      = 1'b1;
            end
            if (adv) begin
                t_d.cnt = t_q.cnt + 1'b1;
                if (t_d.cnt >= limit) begin
                    t_d.done    = 1'b1;
                    t_d.expired = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end

    assign expired = t_q.expired;
    assign running = run && !pause && !t_q.done;

endmodule : cffr_safety_timer
`default_nettype wire

// file: logic/cffr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cffr_sync #(
    parameter int               W   = 1,
    parameter logic [W-1:0]     RST = '0
) (
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic [W-1:0]   async_in,
    output logic      [W-1:0]   sync_out
);

    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] out;
    } cffr_sync_t;

    cffr_sync_t s_q, s_d;
    logic [W-1:0] agree;

    always_comb begin
        s_d     = s_q;
        s_d.ff1 = async_in;
        s_d.ff2 = s_q.ff1;
        s_d.ff3 = s_q.ff2;
        // Change counts only once the second and third stage agree
        agree   = ~(s_q.ff2 ^ s_q.ff3);
        s_d.out = (s_q.ff3 & agree) | (s_q.out & ~agree);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{ff1: RST, ff2: RST, ff3: RST, out: RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.out;

endmodule : cffr_sync
`default_nettype wire
